// ### design/cbcs_pkg.sv
package cbcs_pkg;

   localparam int CODE_W = 5;
   localparam int PAGE_W = 8;
   localparam int BR_IDX_W = 2;

   // Cycle classes presented by the execution unit, one per CPU cycle
   typedef enum logic [CODE_W-1:0] {
      CY_FREE    = 5'h00,
      CY_PFETCH  = 5'h01,
      CY_OPT     = 5'h02,
      CY_PG_RD   = 5'h03,
      CY_IND_PTR = 5'h04,
      CY_IND_PG  = 5'h05,
      CY_PG_WR   = 5'h06,
      CY_RD8     = 5'h07,
      CY_RD16    = 5'h08,
      CY_PUSH8   = 5'h09,
      CY_PUSH16  = 5'h0a,
      CY_WR8     = 5'h0b,
      CY_WR16    = 5'h0c,
      CY_PULL8   = 5'h0d,
      CY_PULL16  = 5'h0e,
      CY_VEC     = 5'h0f,
      CY_CRD8    = 5'h10,
      CY_CRD16   = 5'h11,
      CY_CWR8    = 5'h12
   } cbcs_cyc_e;

   // Stretch states, Gray ordered along bus -> second half -> misalign -> slow
   typedef enum logic [1:0] {
      ST_BUS  = 2'b00,
      ST_HALF = 2'b01,
      ST_MIS  = 2'b11,
      ST_SLOW = 2'b10
   } cbcs_st_e;

   localparam logic [BR_IDX_W-1:0] BR_SHORT_NT_LEN = 2'h1;
   localparam logic [BR_IDX_W-1:0] BR_SHORT_TK_LEN = 2'h3;
   localparam logic [BR_IDX_W:0]   BR_LONG_NT_LEN  = 3'h3;
   localparam logic [BR_IDX_W:0]   BR_LONG_TK_LEN  = 3'h4;
   localparam logic [PAGE_W-1:0]   PAGE_RST        = 8'h00;

endpackage : cbcs_pkg

// ### design/cbcs_opt_resolver.sv
`timescale 1ns/10ps
module cbcs_opt_resolver
   import cbcs_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst,
   input  wire logic      take,
   input  wire logic      insn_start,
   input  wire logic      is_prebyte,
   input  wire logic      first_mis,
   input  wire logic      odd_len,
   input  wire cbcs_cyc_e code_in,
   output cbcs_cyc_e      code_out
);

   logic pb_seen_q;
   logic pb_seen_d;
   logic pb_fetch_q;
   logic pb_fetch_d;
   logic seen_now;
   logic fetch_now;

   always_comb
   begin
      code_out   = code_in;
      seen_now   = insn_start ? 1'b0 : pb_seen_q;
      fetch_now  = insn_start ? 1'b0 : pb_fetch_q;
      pb_seen_d  = seen_now;
      pb_fetch_d = fetch_now;
      if (code_in == CY_OPT)
      begin
         if (is_prebyte)
         begin
            code_out   = first_mis ? CY_PFETCH : CY_FREE;
            pb_seen_d  = 1'b1;
            pb_fetch_d = first_mis;
         end
         else if (seen_now)
            code_out = fetch_now ? CY_FREE : CY_PFETCH;
         else
            code_out = (first_mis && odd_len) ? CY_PFETCH : CY_FREE;
      end
   end

   // Only a cycle the CPU actually completes may advance the prebyte history
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pb_seen_q  <= 1'b0;
         pb_fetch_q <= 1'b0;
      end
      else if (take)
      begin
         pb_seen_q  <= pb_seen_d;
         pb_fetch_q <= pb_fetch_d;
      end
   end

endmodule : cbcs_opt_resolver

// ### design/cbcs_sequencer.sv
`timescale 1ns/10ps
module cbcs_sequencer
   import cbcs_pkg::*;
(
   input  wire logic              CLK,
   input  wire logic              RST,
   input  wire logic              CYC_VALID,
   input  wire cbcs_cyc_e         CYC_CODE,
   input  wire logic              CYC_INSN_START,
   input  wire logic              CYC_PREBYTE,
   input  wire logic              CYC_ODD_LEN,
   input  wire logic              CYC_MISALIGNED,
   input  wire logic              CYC_ADDR_EXT,
   input  wire logic              CYC_COND_HIT,
   input  wire logic [PAGE_W-1:0] CYC_PAGE_WDATA,
   input  wire logic              BR_REQ,
   input  wire logic              BR_LONG,
   input  wire logic              BR_TAKEN,
   input  wire logic              EXT_BUS_NARROW,
   input  wire logic              PGM_EXT,
   input  wire logic              STACK_EXT,
   input  wire logic              SLOW_CS,
   input  wire logic              MISALIGN_OK,
   input  wire logic              STRETCH_REQ,
   output logic                   CPU_CLK_EN,
   output logic                   BR_BUSY,
   output cbcs_cyc_e              ACC_CODE,
   output logic                   ACC_VALID,
   output logic                   ACC_WIDE,
   output logic                   ACC_WRITE,
   output logic                   ACC_HIGH_HALF,
   output logic                   BUS_FREE,
   output logic [PAGE_W-1:0]      PAGE_RD_DATA,
   output logic [PAGE_W-1:0]      PROGRAM_PAGE
);

   cbcs_st_e              st_q;
   cbcs_st_e              st_d;
   logic                  half_q;
   logic                  half_d;
   logic                  mis_q;
   logic                  mis_d;
   logic                  slow_q;
   logic                  slow_d;
   logic                  hold;
   logic                  take;

   logic                  br_busy_q;
   logic                  br_busy_d;
   logic                  br_long_q;
   logic                  br_long_d;
   logic                  br_tk_q;
   logic                  br_tk_d;
   logic                  br_mis_q;
   logic                  br_mis_d;
   logic [BR_IDX_W:0]     br_idx_q;
   logic [BR_IDX_W:0]     br_idx_d;
   logic                  br_on;
   logic                  br_lng;
   logic                  br_tkn;
   logic [BR_IDX_W:0]     br_idx;
   logic [BR_IDX_W:0]     br_len;

   cbcs_cyc_e             raw_code;
   cbcs_cyc_e             res_code;
   logic                  pre_c;
   logic                  start_c;
   logic                  fmis_c;
   logic                  odd_c;
   logic                  wide_c;
   logic                  bus_c;
   logic                  write_c;
   logic                  tgt_ext;
   logic                  need_half;
   logic                  need_mis;

   cbcs_cyc_e             code_q;
   cbcs_cyc_e             code_d;
   logic                  valid_q;
   logic                  valid_d;
   logic                  wide_q;
   logic                  wide_d;
   logic                  write_q;
   logic                  write_d;
   logic                  hi_q;
   logic                  hi_d;
   logic [PAGE_W-1:0]     page_q;
   logic [PAGE_W-1:0]     page_d;
   logic [PAGE_W-1:0]     prd_q;
   logic [PAGE_W-1:0]     prd_d;

   // Class sequence of a branch: index, long form, taken
   function automatic cbcs_cyc_e br_code(input logic [BR_IDX_W:0] idx,
                                         input logic lng,
                                         input logic tkn);
      br_code = CY_PFETCH;
      if (lng && (idx == 3'h0))
         br_code = CY_OPT;
      else if (lng && !tkn && (idx == 3'h2))
         br_code = CY_OPT;
   endfunction : br_code

   // Stretch control: the CPU clock enable is the only handshake to execution
   always_comb
   begin
      hold = 1'b0;
      st_d = st_q;
      case (st_q)
         ST_BUS:
         begin
            hold = half_q || mis_q || (slow_q && STRETCH_REQ);
            st_d = half_q ? ST_HALF : mis_q ? ST_MIS : (slow_q && STRETCH_REQ) ? ST_SLOW : ST_BUS;
         end
         ST_HALF:
         begin
            hold = mis_q || (slow_q && STRETCH_REQ);
            st_d = mis_q ? ST_MIS : (slow_q && STRETCH_REQ) ? ST_SLOW : ST_BUS;
         end
         ST_MIS:
         begin
            hold = slow_q && STRETCH_REQ;
            st_d = hold ? ST_SLOW : ST_BUS;
         end
         ST_SLOW:
         begin
            hold = STRETCH_REQ;
            st_d = hold ? ST_SLOW : ST_BUS;
         end
         default:
         begin
            hold = 1'b0;
            st_d = ST_BUS;
         end
      endcase
   end

   assign take       = !hold;
   assign CPU_CLK_EN = take;

   // Branch sequencing overrides the execution unit's class stream
   always_comb
   begin
      br_on  = br_busy_q || BR_REQ;
      br_lng = br_busy_q ? br_long_q : BR_LONG;
      br_tkn = br_busy_q ? br_tk_q : BR_TAKEN;
      br_idx = br_busy_q ? br_idx_q : 3'h0;
      if (br_lng)
         br_len = br_tkn ? BR_LONG_TK_LEN : BR_LONG_NT_LEN;
      else
         br_len = {1'b0, br_tkn ? BR_SHORT_TK_LEN : BR_SHORT_NT_LEN};
      br_busy_d = br_busy_q;
      br_long_d = br_long_q;
      br_tk_d   = br_tk_q;
      br_mis_d  = br_mis_q;
      br_idx_d  = br_idx_q;
      if (take && br_on)
      begin
         br_long_d = br_lng;
         br_tk_d   = br_tkn;
         br_mis_d  = br_busy_q ? br_mis_q : CYC_MISALIGNED;
         br_idx_d  = 3'((br_idx + 3'h1));
         br_busy_d = (3'((br_idx + 3'h1)) != br_len);
      end
   end

   assign BR_BUSY = br_busy_q;

   always_comb
   begin
      if (br_on)
      begin
         raw_code = br_code(br_idx, br_lng, br_tkn);
         pre_c    = br_lng && (br_idx == 3'h0);
         start_c  = (br_idx == 3'h0);
         fmis_c   = br_busy_q ? br_mis_q : CYC_MISALIGNED;
         odd_c    = 1'b1;
      end
      else
      begin
         raw_code = CYC_VALID ? CYC_CODE : CY_FREE;
         pre_c    = CYC_VALID && CYC_PREBYTE;
         start_c  = CYC_VALID && CYC_INSN_START;
         fmis_c   = CYC_MISALIGNED;
         odd_c    = CYC_ODD_LEN;
      end
   end

   cbcs_opt_resolver u_opt (
      .clk        (CLK),
      .rst        (RST),
      .take       (take),
      .insn_start (start_c),
      .is_prebyte (pre_c),
      .first_mis  (fmis_c),
      .odd_len    (odd_c),
      .code_in    (raw_code),
      .code_out   (res_code)
   );

   // Classification of the resolved cycle
   always_comb
   begin
      wide_c  = 1'b0;
      bus_c   = 1'b1;
      write_c = 1'b0;
      tgt_ext = CYC_ADDR_EXT;
      case (res_code)
         CY_FREE:    bus_c = 1'b0;
         CY_PG_RD:   bus_c = 1'b0;
         CY_PG_WR:   bus_c = 1'b0;
         CY_PFETCH, CY_VEC:
         begin
            wide_c  = 1'b1;
            tgt_ext = PGM_EXT;
         end
         CY_IND_PTR, CY_RD16:
            wide_c = 1'b1;
         CY_WR16:
         begin
            wide_c  = 1'b1;
            write_c = 1'b1;
         end
         CY_PUSH16:
         begin
            wide_c  = 1'b1;
            write_c = 1'b1;
            tgt_ext = STACK_EXT;
         end
         CY_PULL16:
         begin
            wide_c  = 1'b1;
            tgt_ext = STACK_EXT;
         end
         CY_PUSH8:   write_c = 1'b1;
         CY_WR8:     write_c = 1'b1;
         CY_CRD16:
         begin
            bus_c  = CYC_COND_HIT;
            wide_c = CYC_COND_HIT;
         end
         CY_CRD8:    bus_c = CYC_COND_HIT;
         CY_CWR8:
         begin
            bus_c   = CYC_COND_HIT;
            write_c = CYC_COND_HIT;
         end
         default:    bus_c = 1'b1;
      endcase
   end

   // Program and vector words are always aligned, so only data words can misalign
   assign need_half = wide_c && EXT_BUS_NARROW && tgt_ext;
   assign need_mis  = wide_c && CYC_MISALIGNED && !MISALIGN_OK &&
                      !br_on && (res_code != CY_PFETCH) && (res_code != CY_VEC);

   always_comb
   begin
      half_d  = half_q;
      mis_d   = mis_q;
      slow_d  = slow_q;
      code_d  = code_q;
      valid_d = valid_q;
      wide_d  = wide_q;
      write_d = write_q;
      hi_d    = hi_q;
      page_d  = page_q;
      prd_d   = prd_q;
      if (take)
      begin
         code_d  = res_code;
         valid_d = bus_c;
         wide_d  = wide_c;
         write_d = write_c;
         hi_d    = 1'b0;
         half_d  = need_half;
         mis_d   = need_mis;
         slow_d  = bus_c && SLOW_CS;
         if (res_code == CY_PG_RD)
            prd_d = page_q;
         if (res_code == CY_PG_WR)
            page_d = CYC_PAGE_WDATA;
      end
      else if (st_q == ST_BUS && half_q)
      begin
         half_d = 1'b0;
         hi_d   = 1'b1;
      end
      else if (st_q != ST_SLOW && mis_q)
         mis_d = 1'b0;
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         st_q      <= ST_BUS;
         half_q    <= 1'b0;
         mis_q     <= 1'b0;
         slow_q    <= 1'b0;
         br_busy_q <= 1'b0;
         br_long_q <= 1'b0;
         br_tk_q   <= 1'b0;
         br_mis_q  <= 1'b0;
         br_idx_q  <= 3'h0;
         code_q    <= CY_FREE;
         valid_q   <= 1'b0;
         wide_q    <= 1'b0;
         write_q   <= 1'b0;
         hi_q      <= 1'b0;
         page_q    <= PAGE_RST;
         prd_q     <= PAGE_RST;
      end
      else
      begin
         st_q      <= st_d;
         half_q    <= half_d;
         mis_q     <= mis_d;
         slow_q    <= slow_d;
         br_busy_q <= br_busy_d;
         br_long_q <= br_long_d;
         br_tk_q   <= br_tk_d;
         br_mis_q  <= br_mis_d;
         br_idx_q  <= br_idx_d;
         code_q    <= code_d;
         valid_q   <= valid_d;
         wide_q    <= wide_d;
         write_q   <= write_d;
         hi_q      <= hi_d;
         page_q    <= page_d;
         prd_q     <= prd_d;
      end
   end

   assign ACC_CODE      = code_q;
   assign ACC_VALID     = valid_q;
   assign ACC_WIDE      = wide_q;
   assign ACC_WRITE     = write_q;
   assign ACC_HIGH_HALF = hi_q;
   assign BUS_FREE      = !valid_q;
   assign PAGE_RD_DATA  = prd_q;
   assign PROGRAM_PAGE  = page_q;

endmodule : cbcs_sequencer

// ### dv/cbcs_seq_checker.sv
`timescale 1ns/10ps
module cbcs_seq_checker
   import cbcs_pkg::*;
(
   input wire logic              CLK,
   input wire logic              RST,
   input wire logic              CYC_VALID,
   input wire cbcs_cyc_e         CYC_CODE,
   input wire logic              CYC_MISALIGNED,
   input wire logic              CYC_ADDR_EXT,
   input wire logic [PAGE_W-1:0] CYC_PAGE_WDATA,
   input wire logic              BR_REQ,
   input wire logic              BR_LONG,
   input wire logic              EXT_BUS_NARROW,
   input wire logic              PGM_EXT,
   input wire logic              SLOW_CS,
   input wire logic              STRETCH_REQ,
   input wire logic              CPU_CLK_EN,
   input wire logic              BR_BUSY,
   input wire cbcs_cyc_e         ACC_CODE,
   input wire logic              ACC_VALID,
   input wire logic              ACC_WIDE,
   input wire logic              ACC_HIGH_HALF,
   input wire logic [PAGE_W-1:0] PAGE_RD_DATA,
   input wire logic [PAGE_W-1:0] PROGRAM_PAGE
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   logic take;
   logic quick;
   // Branch sequences own the take, so a presented class only counts outside them
   assign take = CPU_CLK_EN && CYC_VALID && !BR_BUSY && !BR_REQ;
   assign quick = take && !SLOW_CS && EXT_BUS_NARROW;

   sequence s_double;
      !CPU_CLK_EN && ACC_WIDE && !ACC_HIGH_HALF ##1 CPU_CLK_EN && ACC_HIGH_HALF;
   endsequence

   chk_free_no_stall:
   assert property (!ACC_VALID |-> CPU_CLK_EN) else $error("free cycle stretched");
   chk_page_write:
   assert property (take && CYC_CODE == CY_PG_WR |=> !ACC_VALID && PROGRAM_PAGE == $past(CYC_PAGE_WDATA))
      else $error("page write wrong");
   chk_page_read:
   assert property (take && CYC_CODE == CY_PG_RD |=> !ACC_VALID && PAGE_RD_DATA == $past(PROGRAM_PAGE))
      else $error("page read wrong");
   chk_data_double:
   assert property (quick && CYC_ADDR_EXT && !CYC_MISALIGNED && CYC_CODE inside {CY_RD16, CY_WR16, CY_IND_PTR}
      |=> s_double) else $error("data word not doubled");
   chk_fetch_double:
   assert property (quick && PGM_EXT && CYC_CODE inside {CY_PFETCH, CY_VEC} |=> s_double)
      else $error("fetch not doubled");
   chk_byte_single:
   assert property (take && !SLOW_CS && CYC_CODE inside {CY_RD8, CY_WR8, CY_PUSH8, CY_PULL8, CY_IND_PG}
      |=> CPU_CLK_EN && ACC_VALID && !ACC_WIDE) else $error("byte cycle stretched");
   chk_slow_hold:
   assert property (ACC_VALID && SLOW_CS && STRETCH_REQ |-> !CPU_CLK_EN) else $error("slow request ignored");
   chk_short_branch:
   assert property (BR_REQ && !BR_BUSY && CPU_CLK_EN && !BR_LONG |=> ACC_CODE == CY_PFETCH && ACC_VALID)
      else $error("short branch not a fetch");
endmodule : cbcs_seq_checker

// ### dv/cbcs_mem_model.sv
`timescale 1ns/10ps
module cbcs_mem_model
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       clk_en,
   input  wire logic       acc_valid,
   input  wire logic       slow_cs,
   input  wire logic       force_req,
   input  wire logic [3:0] wait_n,
   output logic            stretch_req
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;

   // Restarts at every completed CPU cycle, so each slow access waits wait_n clocks
   always_comb
      cnt_d = clk_en ? 4'h0 : cnt_q + 4'h1;

   always_ff @(posedge clk or posedge rst)
      if (rst)
         cnt_q <= 4'h0;
      else
         cnt_q <= cnt_d;

   // force_req is a commanded misbehaviour: a hold request with no slow access behind it
   assign stretch_req = (acc_valid && slow_cs && cnt_q < wait_n) || force_req;
endmodule : cbcs_mem_model

// ### dv/cbcs_sequencer_test.sv
`timescale 1ns/10ps
module cbcs_sequencer_test
   import cbcs_pkg::*;
;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       cyc_valid = 1'b0;
   cbcs_cyc_e  cyc_code = CY_FREE;
   logic [5:0] fl = 6'h00;
   logic [4:0] cfg = 5'h00;
   logic [7:0] wdata = 8'h00;
   logic       br_req = 1'b0;
   logic [1:0] br_lt = 2'h0;
   logic       force_req = 1'b0;
   logic [3:0] wait_n = 4'h0;
   logic       stretch_req, clk_en, br_busy, acc_valid, acc_wide, acc_write, half, bus_free;
   cbcs_cyc_e  acc_code;
   logic [7:0] page_rd, page;
   int         fail_count = 0;
   int         tests_run = 0;
   int         cycles = 0;
   cbcs_cyc_e  tc[15] = '{CY_RD8, CY_RD16, CY_WR8, CY_WR16, CY_PUSH8, CY_PUSH16, CY_PULL8, CY_PULL16,
                          CY_IND_PTR, CY_IND_PG, CY_VEC, CY_PFETCH, CY_CRD8, CY_CRD16, CY_CWR8};
   // Expected {valid, wide, write} per class above
   logic [2:0] tk[15] = '{3'h4, 3'h6, 3'h5, 3'h7, 3'h5, 3'h7, 3'h4, 3'h6, 3'h6, 3'h4, 3'h6, 3'h6, 3'h4, 3'h6, 3'h5};

   always #4 clk = ~clk;

   // fl: insn start, prebyte, odd, misaligned, ext, hit; cfg: narrow, pgm ext, stack ext, slow, misalign ok
   cbcs_sequencer i_cbcs_sequencer (.CLK(clk), .RST(rst), .CYC_VALID(cyc_valid), .CYC_CODE(cyc_code),
      .CYC_INSN_START(fl[5]), .CYC_PREBYTE(fl[4]), .CYC_ODD_LEN(fl[3]), .CYC_MISALIGNED(fl[2]),
      .CYC_ADDR_EXT(fl[1]), .CYC_COND_HIT(fl[0]), .CYC_PAGE_WDATA(wdata), .BR_REQ(br_req),
      .BR_LONG(br_lt[1]), .BR_TAKEN(br_lt[0]), .EXT_BUS_NARROW(cfg[4]), .PGM_EXT(cfg[3]),
      .STACK_EXT(cfg[2]), .SLOW_CS(cfg[1]), .MISALIGN_OK(cfg[0]), .STRETCH_REQ(stretch_req),
      .CPU_CLK_EN(clk_en), .BR_BUSY(br_busy), .ACC_CODE(acc_code), .ACC_VALID(acc_valid),
      .ACC_WIDE(acc_wide), .ACC_WRITE(acc_write), .ACC_HIGH_HALF(half), .BUS_FREE(bus_free),
      .PAGE_RD_DATA(page_rd), .PROGRAM_PAGE(page));

   cbcs_mem_model i_cbcs_mem_model (.clk(clk), .rst(rst), .clk_en(clk_en), .acc_valid(acc_valid),
      .slow_cs(cfg[1]), .force_req(force_req), .wait_n(wait_n), .stretch_req(stretch_req));

   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic cyc(input cbcs_cyc_e c, input logic [5:0] f, input cbcs_cyc_e ec, input logic [2:0] k,
                      input int es);
      int n;
      n = 0;
      cyc_code <= c;
      fl <= f;
      cyc_valid <= 1'b1;
      @(negedge clk);
      while (clk_en !== 1'b1)
         @(negedge clk);
      @(posedge clk);
      cyc_valid <= 1'b0;
      fl <= 6'h00;
      @(negedge clk);
      // A missed conditional cycle may report either class, only its bus use is fixed
      if (f[0] || !(c inside {CY_CRD8, CY_CRD16, CY_CWR8}))
         check(acc_code === ec, "class");
      check(acc_valid === k[2] && (!k[2] || {acc_wide, acc_write} === k[1:0]), "access kind");
      check(bus_free === !k[2], "bus free");
      while (clk_en !== 1'b1 && n < 40)
      begin
         n++;
         @(negedge clk);
      end
      check(n == es, "stall length");
      @(posedge clk);
   endtask : cyc

   task automatic t_table(input logic [4:0] c);
      cfg <= c;
      for (int i = 0; i < 15; i++)
         cyc(tc[i], 6'b100011, tc[i], tk[i], c[4] && tk[i][1]);
   endtask : t_table

   task automatic t_mis;
      cfg <= 5'h00;
      cyc(CY_RD16, 6'b100100, CY_RD16, 3'h6, 1);
      cyc(CY_IND_PTR, 6'b100100, CY_IND_PTR, 3'h6, 1);
      cfg <= 5'h10;
      cyc(CY_RD16, 6'b100110, CY_RD16, 3'h6, 2);
      // A missed conditional word must neither double nor take the misaligned stretch
      cyc(CY_CRD16, 6'b100110, CY_CRD16, 3'h0, 0);
      cyc(CY_CRD8, 6'b100010, CY_CRD8, 3'h0, 0);
      cfg <= 5'h11;
      cyc(CY_WR16, 6'b100110, CY_WR16, 3'h7, 1);
      cyc(CY_PUSH16, 6'b100100, CY_PUSH16, 3'h7, 0);
   endtask : t_mis

   task automatic t_opt;
      cfg <= 5'h18;
      cyc(CY_OPT, 6'b101100, CY_PFETCH, 3'h6, 1);
      cyc(CY_OPT, 6'b101000, CY_FREE, 3'h0, 0);
      cyc(CY_OPT, 6'b100100, CY_FREE, 3'h0, 0);
      cyc(CY_OPT, 6'b110100, CY_PFETCH, 3'h6, 1);
      cyc(CY_OPT, 6'b001100, CY_FREE, 3'h0, 0);
      cyc(CY_OPT, 6'b110000, CY_FREE, 3'h0, 0);
      cyc(CY_OPT, 6'b001000, CY_PFETCH, 3'h6, 1);
   endtask : t_opt

   task automatic t_slow;
      cfg <= 5'h02;
      wait_n <= 4'h3;
      cyc(CY_RD8, 6'b100000, CY_RD8, 3'h4, 3);
      cyc(CY_PUSH8, 6'b100000, CY_PUSH8, 3'h5, 3);
      cyc(CY_IND_PG, 6'b100000, CY_IND_PG, 3'h4, 3);
      cyc(CY_CWR8, 6'b100001, CY_CWR8, 3'h5, 3);
      force_req <= 1'b1;
      cyc(CY_FREE, 6'b100000, CY_FREE, 3'h0, 0);
      cyc(CY_OPT, 6'b100000, CY_FREE, 3'h0, 0);
      cyc(CY_CWR8, 6'b100000, CY_CWR8, 3'h0, 0);
      wdata <= 8'h5a;
      cyc(CY_PG_WR, 6'b100000, CY_PG_WR, 3'h0, 0);
      cyc(CY_PG_RD, 6'b100000, CY_PG_RD, 3'h0, 0);
      force_req <= 1'b0;
      check(page === 8'h5a && page_rd === 8'h5a, "page value");
   endtask : t_slow

   task automatic brt(input logic [2:0] m, input cbcs_cyc_e e[4], input int len);
      br_lt <= m[2:1];
      fl <= {3'b000, m[0], 2'b00};
      br_req <= 1'b1;
      @(posedge clk);
      br_req <= 1'b0;
      fl <= 6'h00;
      for (int i = 0; i <= len; i++)
      begin
         @(negedge clk);
         check(acc_code === (i < len ? e[i] : CY_FREE) && br_busy === (i + 1 < len), "branch");
         @(posedge clk);
      end
   endtask : brt

   task automatic t_branch;
      cfg <= 5'h00;
      brt(3'b000, '{CY_PFETCH, CY_FREE, CY_FREE, CY_FREE}, 1);
      brt(3'b010, '{CY_PFETCH, CY_PFETCH, CY_PFETCH, CY_FREE}, 3);
      brt(3'b101, '{CY_PFETCH, CY_PFETCH, CY_FREE, CY_FREE}, 3);
      brt(3'b100, '{CY_FREE, CY_PFETCH, CY_PFETCH, CY_FREE}, 3);
      brt(3'b111, '{4{CY_PFETCH}}, 4);
      brt(3'b110, '{CY_FREE, CY_PFETCH, CY_PFETCH, CY_PFETCH}, 4);
   endtask : t_branch

   // Reset in mid-run must drop the page written earlier and accept a request right after release
   task automatic t_reset;
      rst <= 1'b1;
      @(posedge clk);
      check(page === 8'h00 && page_rd === 8'h00 && br_busy === 1'b0 && clk_en === 1'b1, "mid reset");
      rst <= 1'b0;
      @(posedge clk);
      cyc(CY_RD16, 6'b100010, CY_RD16, 3'h6, 0);
   endtask : t_reset

   task test_done;
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         fail_count++;
         test_done();
      end
   end

   initial
   begin
      repeat (20) @(posedge clk);
      check(acc_valid === 1'b0 && bus_free === 1'b1 && clk_en === 1'b1 && page === 8'h00, "reset");
      rst <= 1'b0;
      @(posedge clk);
      t_table(5'h00);
      t_table(5'h1c);
      t_mis();
      t_opt();
      t_slow();
      t_branch();
      t_reset();
      test_done();
   end
endmodule : cbcs_sequencer_test

bind cbcs_sequencer cbcs_seq_checker i_cbcs_seq_checker (.CLK(CLK), .RST(RST), .CYC_VALID(CYC_VALID),
   .CYC_CODE(CYC_CODE), .CYC_MISALIGNED(CYC_MISALIGNED), .CYC_ADDR_EXT(CYC_ADDR_EXT),
   .CYC_PAGE_WDATA(CYC_PAGE_WDATA), .BR_REQ(BR_REQ), .BR_LONG(BR_LONG), .EXT_BUS_NARROW(EXT_BUS_NARROW),
   .PGM_EXT(PGM_EXT), .SLOW_CS(SLOW_CS), .STRETCH_REQ(STRETCH_REQ), .CPU_CLK_EN(CPU_CLK_EN),
   .BR_BUSY(BR_BUSY), .ACC_CODE(ACC_CODE), .ACC_VALID(ACC_VALID), .ACC_WIDE(ACC_WIDE),
   .ACC_HIGH_HALF(ACC_HIGH_HALF), .PAGE_RD_DATA(PAGE_RD_DATA), .PROGRAM_PAGE(PROGRAM_PAGE));
